/* aclr_station.sv */
`timescale 1ns/1ns
module aclr_station
    import aclr_pkg::*;
#(
    parameter int NUM_PEERS   = NUM_PEERS_DEF,
    parameter int TICK_CYCLES = ACK_TICK_CYCLES,
    parameter int PEER_W      = $clog2(NUM_PEERS)
)
(
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 cfg_load,
    input  wire logic [CNT_W-1:0]     cfg_n4,
    input  wire logic [TMR_W-1:0]     cfg_ack_ms,
    input  wire logic                 send_valid,
    output logic                      send_ready,
    input  wire logic [NUM_PEERS-1:0] send_dest,
    input  wire logic                 send_group,
    input  wire logic                 send_global,
    output logic                      tx_valid,
    input  wire logic                 tx_ready,
    output logic                      tx_src_resp,
    output logic [1:0]                tx_kind,
    output logic                      tx_poll,
    output logic [NUM_PEERS-1:0]      tx_dest,
    output logic                      tx_group,
    output logic                      tx_global,
    input  wire logic                 rx_valid,
    input  wire logic                 rx_ok,
    input  wire logic                 rx_src_resp,
    input  wire logic [1:0]           rx_kind,
    input  wire logic                 rx_poll,
    input  wire logic                 rx_to_me,
    input  wire logic [PEER_W-1:0]    rx_src,
    input  wire logic                 busy_clr_valid,
    input  wire logic [PEER_W-1:0]    busy_clr_peer,
    output logic                      stat_valid,
    output logic [NUM_PEERS-1:0]      stat_fail,
    output logic [NUM_PEERS-1:0]      peer_busy
);
    localparam int TICK_W = $clog2(TICK_CYCLES);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_TX   = 2'b10
    } aclr_st_t;

    typedef struct packed {
        aclr_st_t             st;
        logic [TICK_W-1:0]    div;
        logic                 tick;
        logic [CNT_W-1:0]     n4;
        logic [TMR_W-1:0]     ack_ms;
        logic                 keep3;
        logic                 resp_pend;
        logic [PEER_W-1:0]    resp_peer;
        logic                 resend;
        logic                 src_resp;
        logic [1:0]           kind;
        logic                 poll;
        logic [NUM_PEERS-1:0] dest;
        logic                 group;
        logic                 global;
        logic                 stat_valid;
        logic [NUM_PEERS-1:0] stat_fail;
    } aclr_top_t;

    aclr_top_t s;
    aclr_top_t next_s;

    function automatic logic [NUM_PEERS-1:0] peer_bit(input logic [PEER_W-1:0] idx);
        logic [NUM_PEERS-1:0] v;
        v = '0;
        v[idx] = 1'b1;
        return v;
    endfunction : peer_bit

    localparam logic [NUM_PEERS-1:0] SP3_BIT = NUM_PEERS'(1) << SPECIAL3;

    // ****************************************************************
    // Per-peer exchanges
    // ****************************************************************
    logic [NUM_PEERS-1:0] active_v;
    logic [NUM_PEERS-1:0] busy_v;
    logic [NUM_PEERS-1:0] due_v;
    logic [NUM_PEERS-1:0] fail_v;
    logic [NUM_PEERS-1:0] start_v;
    logic [NUM_PEERS-1:0] fire_v;
    logic [NUM_PEERS-1:0] ack_v;
    logic [NUM_PEERS-1:0] nack_v;
    logic [NUM_PEERS-1:0] clr_v;
    logic [NUM_PEERS-1:0] resend_set;
    logic                 rsp_ok;
    logic                 poll_in;
    logic                 can_send;

    // Responses and commands are told apart by the source's leading bit.
    assign rsp_ok  = rx_valid && rx_ok && rx_src_resp == SRC_RESP;          // RL17
    assign poll_in = rx_valid && rx_ok && rx_src_resp == SRC_CMD && rx_kind == PDU_UI
                     && rx_poll == POLL_ON && rx_to_me;                     // RL14
    assign ack_v   = (rsp_ok && rx_kind == PDU_URR) ? peer_bit(rx_src) : '0;
    assign nack_v  = (rsp_ok && rx_kind == PDU_URNR) ? peer_bit(rx_src) : '0;
    assign clr_v   = busy_clr_valid ? peer_bit(busy_clr_peer) : '0;

    // Slot 3 never arms, and peers that already answered or are busy fall out.
    assign resend_set = due_v & ~busy_v & ~SP3_BIT;                         // RL5 RL7

    // No addressed peer may have a live exchange or be busy, and no resend may be due, before a new send.
    assign can_send = s.st == ST_IDLE && !s.resp_pend && !poll_in && resend_set == '0
                      && (send_dest & (active_v | busy_v)) == '0;           // RL13

    assign send_ready = can_send;

    generate
        for (genvar i = 0; i < NUM_PEERS; i++)
        begin : g_slot
            aclr_slot u_slot (
                .ref_clk  (ref_clk),
                .rst      (rst),
                .tick     (s.tick),
                .start    (start_v[i]),
                .ack      (ack_v[i]),
                .nack     (nack_v[i]),
                .busy_clr (clr_v[i]),
                .fire     (fire_v[i]),
                .cfg_n4   (s.n4),
                .cfg_time (s.ack_ms),
                .active   (active_v[i]),
                .busy     (busy_v[i]),
                .due      (due_v[i]),
                .fail     (fail_v[i]),
                .count    ()
            );                                                              // RL9 RL10
        end
    endgenerate

    // ****************************************************************
    // Sequencing
    // ****************************************************************
    always_comb
    begin
        next_s = s;
        start_v = '0;
        fire_v = '0;
        next_s.stat_valid = |fail_v;                                        // RL8
        next_s.stat_fail  = fail_v;
        if (s.div == TICK_W'(TICK_CYCLES - 1))
        begin
            next_s.div  = '0;
            next_s.tick = 1'b1;
        end
        else
        begin
            next_s.div  = s.div + 1'b1;
            next_s.tick = 1'b0;
        end
        // Changing limits mid-exchange would bend live timers, so loads are ignored while any slot is active.
        if (cfg_load && active_v == '0)
        begin
            next_s.n4     = cfg_n4;                                         // RL18
            next_s.ack_ms = cfg_ack_ms;
        end
        if (active_v == '0)
            next_s.keep3 = 1'b0;
        // Only one answer is remembered; a second poll before it leaves wins.
        if (poll_in)
        begin
            next_s.resp_pend = 1'b1;                                        // RL14
            next_s.resp_peer = rx_src;
        end
        case (s.st)
            ST_IDLE:
            begin
                if (s.resp_pend)
                begin
                    next_s.st        = ST_TX;
                    next_s.resp_pend = poll_in;
                    next_s.resend    = 1'b0;
                    next_s.src_resp  = SRC_RESP;
                    next_s.kind      = PDU_URR;
                    next_s.poll      = POLL_ON;
                    next_s.dest      = peer_bit(s.resp_peer);
                    next_s.group     = 1'b0;
                    next_s.global    = 1'b0;
                end
                else if (resend_set != '0)
                begin
                    fire_v           = resend_set;                          // RL4
                    next_s.st        = ST_TX;
                    next_s.resend    = 1'b1;
                    next_s.src_resp  = SRC_CMD;
                    next_s.kind      = PDU_UI;
                    next_s.poll      = POLL_ON;
                    next_s.dest      = resend_set | (s.keep3 ? SP3_BIT : '0); // RL6
                    next_s.group     = 1'b0;                                // RL5
                    next_s.global    = 1'b0;
                end
                else if (send_valid && can_send)
                begin
                    start_v          = send_dest & ~SP3_BIT;                // RL3 RL15
                    next_s.keep3     = send_dest[SPECIAL3];
                    next_s.st        = ST_TX;
                    next_s.resend    = 1'b0;
                    next_s.src_resp  = SRC_CMD;
                    next_s.kind      = PDU_UI;                              // RL2
                    next_s.poll      = POLL_ON;                             // RL1
                    next_s.dest      = send_dest;
                    next_s.group     = send_group;
                    next_s.global    = send_global;
                end
            end
            ST_TX:
            begin
                if (tx_ready)
                    next_s.st = ST_IDLE;
            end
            default:
            begin
                next_s.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s        <= '0;                                                 // RL19
            s.st     <= ST_IDLE;
            s.n4     <= N4_RESET;
            s.ack_ms <= ACK_MS_RESET;
        end
        else
            s <= next_s;
    end

    assign tx_valid    = s.st == ST_TX;
    assign tx_src_resp = s.src_resp;
    assign tx_kind     = s.kind;
    assign tx_poll     = s.poll;
    assign tx_dest     = s.dest;
    assign tx_group    = s.group;
    assign tx_global   = s.global;
    assign stat_valid  = s.stat_valid;
    assign stat_fail   = s.stat_fail;
    assign peer_busy   = busy_v;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_cmd_out;
        tx_valid && tx_src_resp == SRC_CMD;
    endsequence

    sequence s_resend_out;
        tx_valid && s.resend;
    endsequence

    property p_poll;
        @(posedge ref_clk) disable iff (rst)
        s_cmd_out |-> tx_poll == POLL_ON && tx_kind == PDU_UI;
    endproperty
    a_poll: assert property (p_poll) else $error("command without poll bit"); // RL1

    property p_resend_addr;
        @(posedge ref_clk) disable iff (rst)
        s_resend_out |-> !tx_group && !tx_global && (tx_dest & ~SP3_BIT) != '0;
    endproperty
    a_resend_addr: assert property (p_resend_addr) else $error("bad resend list"); // RL7

    property p_busy_block;
        @(posedge ref_clk) disable iff (rst)
        (start_v != '0 || fire_v != '0) |-> ((start_v | fire_v) & busy_v) == '0;
    endproperty
    a_busy_block: assert property (p_busy_block) else $error("sent to busy peer"); // RL13

    property p_urr;
        @(posedge ref_clk) disable iff (rst)
        poll_in |=> s.resp_pend ##[0:8] (tx_valid && tx_kind == PDU_URR) or !tx_ready[*8];
    endproperty
    a_urr: assert property (p_urr) else $error("polled UI not answered"); // RL14

    property p_stat;
        @(posedge ref_clk) disable iff (rst)
        fail_v != '0 |=> stat_valid && stat_fail == $past(fail_v);
    endproperty
    a_stat: assert property (p_stat) else $error("failure not reported"); // RL8

    property p_no3;
        @(posedge ref_clk) disable iff (rst)
        !active_v[SPECIAL3];
    endproperty
    a_no3: assert property (p_no3) else $error("awaiting answer from 3"); // RL15
endmodule : aclr_station

/* aclr_pkg.sv */
// What this block does
// RL1: Every command sent by this procedure has its poll bit at one.
// RL2: Information goes to responding stations as UI command frames.
// RL3: Sending a polled UI starts its ack timer and zeroes its send count.
// RL4: On timer expiry with answers missing, resend, count up, restart timer.
// RL5: Resends drop group, global and already answering addresses.
// RL6: Special address 3 stays in a resend unless it would be alone.
// RL7: No resend unless an individual or non-3 special address remains.
// RL8: Resending stops when the count reaches N4; failure is reported upward.
// RL9: Each peer exchange keeps its own send count.
// RL10: One exchange's timer and count never disturb another peer's exchange.
// RL11: A URNR answer marks the answering peer busy.
// RL12: Resends to a peer follow the busy handling while it is busy.
// RL13: No UI command goes to a busy peer until its busy state clears.
// RL14: A valid polled UI addressed to us is answered by URR to its sender.
// RL15: No answer is awaited from group, global or special address 3.
// RL16: A URR answer stops that peer's timer and zeroes its send count.
// RL17: The first source address bit tells commands from responses.
// RL18: Retry limit and ack time are configuration inputs loaded while idle.
// RL19: Reset clears every busy flag, timer and counter.
package aclr_pkg;
    localparam int          CLK_PERIOD_NS     = 20;
    localparam int          MS_NS             = 1000000;
    localparam int          ACK_TICK_CYCLES   = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          NUM_PEERS_DEF     = 8;
    localparam int          CNT_W             = 4;
    localparam int          TMR_W             = 12;
    localparam int          SPECIAL3          = 3;
    localparam logic [3:0]  N4_RESET          = 4'h3;
    localparam logic [11:0] ACK_MS_RESET      = 12'h3e8;
    localparam logic [1:0]  PDU_UI            = 2'h0;
    localparam logic [1:0]  PDU_URR           = 2'h1;
    localparam logic [1:0]  PDU_URNR          = 2'h2;
    localparam logic        SRC_CMD           = 1'b0;
    localparam logic        SRC_RESP          = 1'b1;
    localparam logic        POLL_ON           = 1'b1;
endpackage : aclr_pkg

/* aclr_slot.sv */
`timescale 1ns/1ns
module aclr_slot
    import aclr_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             tick,
    input  wire logic             start,
    input  wire logic             ack,
    input  wire logic             nack,
    input  wire logic             busy_clr,
    input  wire logic             fire,
    input  wire logic [CNT_W-1:0] cfg_n4,
    input  wire logic [TMR_W-1:0] cfg_time,
    output logic                  active,
    output logic                  busy,
    output logic                  due,
    output logic                  fail,
    output logic [CNT_W-1:0]      count
);
    typedef struct packed {
        logic             active;
        logic             busy;
        logic             due;
        logic             fail;
        logic [CNT_W-1:0] count;
        logic [TMR_W-1:0] timer;
    } aclr_slot_t;

    aclr_slot_t s;
    aclr_slot_t next_s;

    always_comb
    begin
        next_s = s;
        next_s.fail = 1'b0;
        if (busy_clr)
            next_s.busy = 1'b0;
        // Marking busy wins over a clear in the same cycle.
        if (nack && s.active)
            next_s.busy = 1'b1;                                 // RL11
        if (fire && s.due)
        begin
            next_s.due   = 1'b0;
            next_s.count = s.count + 1'b1;                      // RL4
            next_s.timer = cfg_time;
        end
        else if (tick && s.active && !s.busy && !s.due)
        begin
            // A busy peer's timer is frozen so it cannot run out the count.
            if (s.timer <= 1)
            begin
                if (s.count >= cfg_n4)
                begin
                    next_s.active = 1'b0;                       // RL8
                    next_s.fail   = 1'b1;
                end
                else
                    next_s.due = 1'b1;                          // RL12
            end
            else
                next_s.timer = s.timer - 1'b1;
        end
        if (ack)
        begin
            next_s.active = 1'b0;                               // RL16
            next_s.due    = 1'b0;
            next_s.busy   = 1'b0;
            next_s.count  = '0;
        end
        if (start)
        begin
            next_s.active = 1'b1;                               // RL3
            next_s.due    = 1'b0;
            next_s.count  = '0;
            next_s.timer  = cfg_time;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            s <= '0;                                            // RL19
        else
            s <= next_s;
    end

    assign active = s.active;
    assign busy   = s.busy;
    assign due    = s.due;
    assign fail   = s.fail;
    assign count  = s.count;

    property p_start;
        @(posedge ref_clk) disable iff (rst)
        start |=> active && count == '0 && !due;
    endproperty
    a_start: assert property (p_start) else $error("start did not arm slot"); // RL3

    property p_fire;
        @(posedge ref_clk) disable iff (rst)
        fire && due && !start && !ack |=> count == $past(count) + 1'b1 && !due;
    endproperty
    a_fire: assert property (p_fire) else $error("resend did not count up"); // RL4

    property p_ack;
        @(posedge ref_clk) disable iff (rst)
        ack && !start |=> !active && count == '0 && !busy;
    endproperty
    a_ack: assert property (p_ack) else $error("URR did not stop exchange"); // RL16

    property p_nack;
        @(posedge ref_clk) disable iff (rst)
        nack && active |=> busy;
    endproperty
    a_nack: assert property (p_nack) else $error("URNR did not mark busy"); // RL11

    property p_fail;
        @(posedge ref_clk) disable iff (rst)
        fail |-> !active && $past(count) >= $past(cfg_n4);
    endproperty
    a_fail: assert property (p_fail) else $error("failure before limit"); // RL8
endmodule : aclr_slot

/* aclr_peer_model.sv */
`timescale 1ns/1ns
// ****************************************************************
// Remote stations on the shared network
// ****************************************************************
module aclr_peer_model
    import aclr_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       stall,
    input  wire logic [3:0] lag,
    input  wire logic [7:0] urr_mask,
    input  wire logic [7:0] urnr_mask,
    input  wire logic       inj,
    input  wire logic [2:0] inj_src,
    input  wire logic       tx_valid,
    input  wire logic [1:0] tx_kind,
    input  wire logic [7:0] tx_dest,
    output logic            tx_ready,
    output logic            rx_valid,
    output logic            rx_ok,
    output logic            rx_src_resp,
    output logic [1:0]      rx_kind,
    output logic            rx_poll,
    output logic            rx_to_me,
    output logic [2:0]      rx_src
);
    logic [7:0] pend_urr;
    logic [7:0] pend_urnr;
    logic [7:0] pick;
    logic [3:0] wait_cnt;

    assign tx_ready = !stall;

    // URR answers leave before URNR answers; each peer answers once.
    assign pick = (inj || wait_cnt != 4'h0) ? 8'h00
                : (pend_urr != 8'h00) ? pend_urr & (~pend_urr + 8'h01)
                : pend_urnr & (~pend_urnr + 8'h01);

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            {pend_urr, pend_urnr, wait_cnt} <= '0;
            {rx_valid, rx_ok, rx_src_resp, rx_kind, rx_poll, rx_to_me, rx_src} <= '0;
        end
        else
        begin
            // Lines keep moving between frames, so a stale frame never looks valid.
            rx_valid <= 1'b0;
            {rx_ok, rx_src_resp, rx_poll, rx_to_me} <= ~{rx_ok, rx_src_resp, rx_poll, rx_to_me};
            rx_kind <= rx_kind + 2'h1;
            rx_src  <= rx_src + 3'h1;
            if (inj)
            begin
                {rx_valid, rx_ok, rx_src_resp, rx_kind} <= {1'b1, 1'b1, SRC_CMD, PDU_UI};
                {rx_poll, rx_to_me, rx_src} <= {POLL_ON, 1'b1, inj_src};
            end
            else if (wait_cnt != 4'h0)
                wait_cnt <= wait_cnt - 4'h1;
            else if ((pend_urr | pend_urnr) != 8'h00)
            begin
                {rx_valid, rx_ok, rx_src_resp} <= {1'b1, 1'b1, SRC_RESP};
                rx_kind  <= (pend_urr != 8'h00) ? PDU_URR : PDU_URNR;
                {rx_poll, rx_to_me} <= {POLL_ON, 1'b1};
                for (int i = 0; i < 8; i++)
                    if (pick[i])
                        rx_src <= 3'(i);
                wait_cnt <= lag;
            end
            pend_urr  <= pend_urr & ~pick;
            pend_urnr <= pend_urnr & ~pick;
            if (tx_valid && tx_ready && tx_kind == PDU_UI)
            begin
                pend_urr  <= (pend_urr & ~pick) | (tx_dest & urr_mask);
                pend_urnr <= (pend_urnr & ~pick) | (tx_dest & urnr_mask & ~urr_mask);
            end
        end
    end
endmodule : aclr_peer_model

/* test_acked_connectionless_retransmit.sv */
`timescale 1ns/1ns
module test_acked_connectionless_retransmit
    import aclr_pkg::*;
;
    typedef struct {logic [7:0] dest; logic grp, glb; logic [7:0] urr, rs; int n;
                    logic [7:0] fl;} aclr_row_t;
    logic ref_clk, rst, cfg_load, send_valid, send_ready, send_group, send_global, inj;
    logic tx_valid, tx_ready, tx_src_resp, tx_poll, tx_group, tx_global, stall;
    logic rx_valid, rx_ok, rx_src_resp, rx_poll, rx_to_me, busy_clr_valid, stat_valid;
    logic [1:0] tx_kind, rx_kind;
    logic [2:0] rx_src, busy_clr_peer, inj_src;
    logic [3:0] cfg_n4, lag;
    logic [11:0] cfg_ack_ms;
    logic [7:0] send_dest, tx_dest, stat_fail, peer_busy, urr_mask, urnr_mask;
    logic [7:0] exp_first, exp_rs, fail_acc;
    int ui_cnt, urr_cnt, bad_count, samples_checked;
    // Fields: dest, group, global, answering peers, resend mask, resends, failed.
    aclr_row_t rows[7] = '{'{8'h02, 0, 0, 8'h02, 8'h00, 0, 8'h00},
                           '{8'h02, 0, 0, 8'h00, 8'h02, 2, 8'h02},
                           '{8'h06, 1, 1, 8'h04, 8'h02, 2, 8'h02},
                           '{8'h0a, 0, 0, 8'h00, 8'h0a, 2, 8'h02},
                           '{8'h08, 1, 0, 8'h00, 8'h00, 0, 8'h00},
                           '{8'h0a, 0, 0, 8'h02, 8'h00, 0, 8'h00},
                           '{8'h30, 0, 0, 8'h10, 8'h20, 2, 8'h20}};

    aclr_station #(.NUM_PEERS(8), .TICK_CYCLES(4)) dut (.ref_clk, .rst, .cfg_load, .cfg_n4,
        .cfg_ack_ms, .send_valid, .send_ready, .send_dest, .send_group, .send_global,
        .tx_valid, .tx_ready, .tx_src_resp, .tx_kind, .tx_poll, .tx_dest, .tx_group,
        .tx_global, .rx_valid, .rx_ok, .rx_src_resp, .rx_kind, .rx_poll, .rx_to_me,
        .rx_src, .busy_clr_valid, .busy_clr_peer, .stat_valid, .stat_fail, .peer_busy);
    aclr_peer_model peer (.ref_clk, .rst, .stall, .lag, .urr_mask, .urnr_mask, .inj,
        .inj_src, .tx_valid, .tx_kind, .tx_dest, .tx_ready, .rx_valid, .rx_ok,
        .rx_src_resp, .rx_kind, .rx_poll, .rx_to_me, .rx_src);

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            bad_count++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, want);
        end
    endtask : check

    task give_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    // A request is held until the edge at which send_ready is seen high.
    task send(input logic [7:0] d, input logic g, input logic l);
        int i;
        @(posedge ref_clk);
        #2 {send_valid, send_dest, send_group, send_global} = {1'b1, d, g, l};
        @(negedge ref_clk);
        for (i = 0; i < 200 && send_ready !== 1'b1; i++)
            @(negedge ref_clk);
        @(posedge ref_clk);
        #2 send_valid = 1'b0;
    endtask : send

    task wait_fail(input int n);
        for (int i = 0; i < n && fail_acc == 8'h00; i++)
            @(posedge ref_clk);
        repeat (4) @(posedge ref_clk);
    endtask : wait_fail

    task prime(input logic [7:0] ur, input logic [7:0] un, input logic [7:0] f,
               input logic [7:0] r);
        {urr_mask, urnr_mask, exp_first, exp_rs, fail_acc} = {ur, un, f, r, 8'h00};
        ui_cnt = 0;
    endtask : prime

    // ****************************************************************
    // Frame monitor
    // ****************************************************************
    always @(posedge ref_clk)
    begin
        if (!rst && tx_valid && tx_ready)
        begin
            check(tx_poll, POLL_ON);
            if (tx_kind == PDU_UI)
            begin
                check(tx_src_resp, SRC_CMD);
                check(tx_dest, ui_cnt == 0 ? exp_first : exp_rs);
                check({tx_group, tx_global}, ui_cnt ? 2'b00 : {send_group, send_global});
                ui_cnt++;
            end
            else
            begin
                check(tx_src_resp, SRC_RESP);
                urr_cnt++;
            end
        end
        if (stat_valid === 1'b1)
            fail_acc |= stat_fail;
    end

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        give_verdict;
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        {rst, cfg_load, cfg_n4, cfg_ack_ms, send_valid, send_dest} = {1'b1, 1'b0, 4'h0, 12'h0,
                                                                      1'b0, 8'h00};
        {send_group, send_global, busy_clr_valid, busy_clr_peer, stall, inj} = '0;
        {inj_src, lag, urr_mask, urnr_mask, ui_cnt, urr_cnt, bad_count} = '0;
        {samples_checked, fail_acc} = '0;
        repeat (8) @(posedge ref_clk);
        #2 rst = 1'b0;
        @(negedge ref_clk);
        check({tx_valid, send_ready, stat_valid, peer_busy}, {3'b010, 8'h00});
        $display("reset test done");
        @(posedge ref_clk);
        #2 {cfg_load, cfg_n4, cfg_ack_ms} = {1'b1, 4'h2, 12'h003};
        @(posedge ref_clk);
        #2 cfg_load = 1'b0;
        foreach (rows[k])
        begin
            prime(rows[k].urr, 8'h00, rows[k].dest, rows[k].rs);
            lag = 4'(k);
            send(rows[k].dest, rows[k].grp, rows[k].glb);
            wait_fail(150);
            check(ui_cnt, rows[k].n + 1);
            check(fail_acc, rows[k].fl);
            $display("row %0d done", k);
        end
        prime(8'h00, 8'h04, 8'h04, 8'h04);
        send(8'h04, 1'b0, 1'b0);
        repeat (60) @(posedge ref_clk);
        check(peer_busy, 8'h04);
        check(ui_cnt, 1);
        #2 {urnr_mask, send_valid, send_dest} = {8'h00, 1'b1, 8'h04};
        @(negedge ref_clk);
        check(send_ready, 1'b0);
        @(posedge ref_clk);
        #2 {send_valid, busy_clr_valid, busy_clr_peer} = {1'b0, 1'b1, 3'h2};
        {cfg_load, cfg_n4} = {1'b1, 4'h5};
        @(posedge ref_clk);
        #2 {busy_clr_valid, cfg_load} = 2'b00;
        @(negedge ref_clk);
        check(peer_busy, 8'h00);
        wait_fail(150);
        check(ui_cnt, 3);
        check(fail_acc, 8'h04);
        $display("busy test done");
        #2 {stall, inj, inj_src} = {1'b1, 1'b1, 3'h5};
        @(posedge ref_clk);
        #2 inj = 1'b0;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        check({tx_valid, tx_kind, tx_dest}, {1'b1, PDU_URR, 8'h20});
        @(posedge ref_clk);
        #2 stall = 1'b0;
        repeat (2) @(negedge ref_clk);
        check(tx_valid, 1'b0);
        check(urr_cnt, 1);
        $display("answer test done");
        // A reset in mid-exchange must leave no busy peer and no live slot behind.
        prime(8'h00, 8'h40, 8'h40, 8'h40);
        send(8'h40, 1'b0, 1'b0);
        repeat (20) @(posedge ref_clk);
        check(peer_busy, 8'h40);
        #2 rst = 1'b1;
        @(posedge ref_clk);
        #2 rst = 1'b0;
        @(negedge ref_clk);
        check({tx_valid, send_ready, stat_valid, peer_busy}, {3'b010, 8'h00});
        $display("second reset test done");
        give_verdict;
    end
endmodule : test_acked_connectionless_retransmit
